// ===== rtl/brh_bus_release_ctrl.sv
`default_nettype none
module brh_bus_release_ctrl import brh_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_phi1,
  input wire logic i_phi2,
  input wire logic i_data_drive_strobe,
  input wire logic i_three_state_control,
  input wire logic i_halt_n,
  input wire logic i_res_n,
  input wire logic i_irq_n,
  input wire logic i_nmi_n,
  input wire logic [15:0] i_core_addr,
  input wire logic i_core_rw,
  input wire logic i_core_valid_addr,
  input wire logic [7:0] i_core_wdata,
  input wire logic i_core_last_cycle,
  input wire logic i_core_irq_ack,
  input wire logic i_core_nmi_ack,
  input wire logic i_core_res_ack,
  output logic [15:0] o_addr,
  output logic o_addr_oe_n,
  output logic o_rw,
  output logic o_rw_oe_n,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_valid_memory_address,
  output logic o_ba,
  output logic o_core_run,
  output logic o_core_irq_pend,
  output logic o_core_nmi_pend,
  output logic o_core_res_pend
);
  logic [PIN_N-1:0] pins_raw, pins;
  logic phi1_s, phi2_s, dds_s, three_state_s, halt_s, res_s, irq_s, nmi_s;

  assign pins_raw = {i_nmi_n, i_irq_n, i_res_n, i_halt_n,
                     i_three_state_control, i_data_drive_strobe,
                     i_phi2, i_phi1};

  brh_pin_sync #(.N(PIN_N), .INIT(PIN_RST)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(pins_raw),
    .o_q(pins)
  );

  assign phi1_s = pins[PIN_PHI1];
  assign phi2_s = pins[PIN_PHI2];
  assign dds_s = pins[PIN_DDS];
  assign three_state_s = pins[PIN_THREE_STATE];
  assign halt_s = pins[PIN_HALT_N];
  assign res_s = pins[PIN_RES_N];
  assign irq_s = pins[PIN_IRQ_N];
  assign nmi_s = pins[PIN_NMI_N];

  // control state
  brh_state_t st, next_st;
  logic [WIN_W-1:0] win_cnt, next_win_cnt;
  logic halt_take, next_halt_take;
  logic prev_phi1, prev_phi2, prev_nmi;
  logic irq_pend, nmi_pend, res_pend;
  logic next_irq_pend, next_nmi_pend, next_res_pend;
  logic phi1_rise, phi2_rise, in_win;

  assign phi1_rise = phi1_s & ~prev_phi1;
  assign phi2_rise = phi2_s & ~prev_phi2;
  assign in_win = phi1_rise | (win_cnt < HALT_WIN_CYC);

  always_comb begin
    next_st = st;
    next_halt_take = halt_take;
    if (phi1_rise) begin
      next_win_cnt = '0;
    end else if (win_cnt != HALT_WIN_CYC) begin
      next_win_cnt = win_cnt + WIN_W'(1);
    end else begin
      next_win_cnt = win_cnt;
    end
    // requests are held until the core takes them; a new one wins
    next_irq_pend = ~irq_s | (irq_pend & ~i_core_irq_ack);
    next_nmi_pend = (prev_nmi & ~nmi_s) | (nmi_pend & ~i_core_nmi_ack);
    next_res_pend = ~res_s | (res_pend & ~i_core_res_ack);
    if (!res_s) begin
      // reset overrides a halt at once
      next_st = ST_RESET;
      next_halt_take = 1'b0;
    end else begin
      unique case (st)
        ST_RUN: begin
          if (phi1_rise && halt_take) begin
            // instruction ended at this phase-one edge
            next_st = ST_STOP;
            next_halt_take = 1'b0;
          end else if (in_win && i_core_last_cycle && !halt_s) begin
            // later sampling defers halting one instruction
            next_halt_take = 1'b1;
          end
        end
        ST_STOP: begin
          if (phi2_rise) begin
            next_st = ST_HALT;
          end
        end
        ST_HALT: begin
          // a one-cycle high pulse runs exactly one instruction
          if (phi1_rise && halt_s) begin
            next_st = ST_RUN;
          end
        end
        ST_RESET: begin
          next_st = ST_RUN;
        end
        default: begin
          next_st = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= ST_RESET;
      win_cnt <= HALT_WIN_CYC;
      halt_take <= 1'b0;
      prev_phi1 <= 1'b0;
      prev_phi2 <= 1'b0;
      prev_nmi <= 1'b1;
      irq_pend <= 1'b0;
      nmi_pend <= 1'b0;
      res_pend <= 1'b0;
    end else begin
      st <= next_st;
      win_cnt <= next_win_cnt;
      halt_take <= next_halt_take;
      prev_phi1 <= phi1_s;
      prev_phi2 <= phi2_s;
      prev_nmi <= nmi_s;
      irq_pend <= next_irq_pend;
      nmi_pend <= next_nmi_pend;
      res_pend <= next_res_pend;
    end
  end

  // pin outputs, registered from the next state
  logic [15:0] next_addr;
  logic [7:0] next_data;
  logic next_addr_oe_n, next_rw, next_rw_oe_n, next_data_oe_n;
  logic next_valid_addr, next_ba, next_core_run, bus_own, in_rst;

  always_comb begin
    in_rst = (next_st == ST_RESET);
    // three-state control releases address and rw in any state
    bus_own = (next_st != ST_HALT) && !three_state_s;
    next_addr = in_rst ? RESTART_ADDR : i_core_addr;
    next_addr_oe_n = !bus_own;
    next_rw = in_rst ? 1'b1 : i_core_rw;
    next_rw_oe_n = !bus_own;
    next_valid_addr = (next_st == ST_RUN) && !three_state_s &&
                      i_core_valid_addr;
    next_ba = (next_st == ST_HALT) && !three_state_s;
    // strobe gates the data drivers; a read never drives
    next_data_oe_n = !(dds_s && !next_rw &&
                       next_st == ST_RUN);
    next_data = i_core_wdata;
    next_core_run = (next_st == ST_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_addr <= ADDR_RST;
      o_addr_oe_n <= 1'b1;
      o_rw <= 1'b1;
      o_rw_oe_n <= 1'b1;
      o_data <= DATA_RST;
      o_data_oe_n <= 1'b1;
      o_valid_memory_address <= 1'b0;
      o_ba <= 1'b0;
      o_core_run <= 1'b0;
    end else begin
      o_addr <= next_addr;
      o_addr_oe_n <= next_addr_oe_n;
      o_rw <= next_rw;
      o_rw_oe_n <= next_rw_oe_n;
      o_data <= next_data;
      o_data_oe_n <= next_data_oe_n;
      o_valid_memory_address <= next_valid_addr;
      o_ba <= next_ba;
      o_core_run <= next_core_run;
    end
  end

  assign o_core_irq_pend = irq_pend;
  assign o_core_nmi_pend = nmi_pend;
  assign o_core_res_pend = res_pend;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_strobe_float: assert property (
    !dds_s |=> o_data_oe_n)
    else $error("data driven while strobe low");
  chk_read_float: assert property (
    (i_core_rw && res_s) |=> o_data_oe_n)
    else $error("data driven during read");
  chk_release_float: assert property (
    three_state_s |=> (o_addr_oe_n && o_rw_oe_n && !o_valid_memory_address))
    else $error("bus not released under three-state control");
  chk_release_ba_low: assert property (
    three_state_s |=> !o_ba)
    else $error("bus-available high under three-state control");
  chk_halt_latch: assert property (
    (st == ST_HALT && !irq_s) |=> o_core_irq_pend [*2])
    else $error("interrupt lost while halted");
  chk_reset_outs: assert property (
    !res_s |=> (o_addr == RESTART_ADDR && o_rw && !o_ba &&
                !o_valid_memory_address && o_data_oe_n))
    else $error("reset output state wrong");
  chk_ba_rise: assert property (
    (st == ST_STOP && phi2_rise && res_s && !three_state_s) |=> o_ba)
    else $error("bus-available late after phase-two edge");
  chk_halt_window: assert property (
    (st == ST_RUN && in_win && i_core_last_cycle && !halt_s && res_s)
      |=> (halt_take || st == ST_STOP))
    else $error("halt in window not taken");
  chk_halt_release: assert property (
    (st == ST_HALT && phi1_rise && halt_s && res_s)
      |=> (o_core_run && !o_ba))
    else $error("halt release did not resume");
  chk_halt_idle: assert property (
    o_ba |-> (!o_core_run && o_addr_oe_n && o_data_oe_n &&
              !o_valid_memory_address))
    else $error("bus driven while halted");
endmodule // brh_bus_release_ctrl
`default_nettype wire

// ===== rtl/brh_pin_sync.sv
`default_nettype none
module brh_pin_sync import brh_pkg::*; #(
  parameter int N = PIN_N,
  parameter logic [N-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [N-1:0] i_d,
  output logic [N-1:0] o_q
);
  logic [N-1:0] ff1, ff2, ff3, q;
  logic [N-1:0] next_q;

  // a level is accepted only once two settled stages agree
  always_comb begin
    next_q = q;
    for (int i = 0; i < N; i++) begin
      if (ff2[i] == ff3[i]) begin
        next_q[i] = ff2[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ff1 <= INIT;
      ff2 <= INIT;
      ff3 <= INIT;
      q <= INIT;
    end else begin
      ff1 <= i_d;
      ff2 <= ff1;
      ff3 <= ff2;
      q <= next_q;
    end
  end

  assign o_q = q;
endmodule // brh_pin_sync
`default_nettype wire

// ===== rtl/brh_pkg.sv
// Notes on behaviour
// - data pins driven only while strobe high
// - data pins float during every read cycle
// - three-state control floats address, rw; valid-address low
// - three-state control forces bus-available low
// - interrupts and reset latched while halted
// - reset while halted gives restart bus state
// - finish instruction, bus-available after phase-two edge
// - halt sampled early in last cycle
// - bus-available rises 2 to 14 cycles later
// - one-cycle halt release steps one instruction
// - reset drives restart outputs promptly
// - halted device floats bus, valid-address low
`default_nettype none
package brh_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALT_WIN_NS = 100;
  // a window is a longest time, so the count rounds down
  localparam int HALT_WIN_CYC_I = HALT_WIN_NS / CLK_PERIOD_NS;
  localparam int WIN_W = 4;
  localparam logic [WIN_W-1:0] HALT_WIN_CYC = WIN_W'(HALT_WIN_CYC_I);
  localparam logic [15:0] RESTART_ADDR = 16'hfffe;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int PIN_N = 8;
  localparam int PIN_PHI1 = 0;
  localparam int PIN_PHI2 = 1;
  localparam int PIN_DDS = 2;
  localparam int PIN_THREE_STATE = 3;
  localparam int PIN_HALT_N = 4;
  localparam int PIN_RES_N = 5;
  localparam int PIN_IRQ_N = 6;
  localparam int PIN_NMI_N = 7;
  localparam logic [PIN_N-1:0] PIN_RST = 8'hf0;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_STOP = 4'h2,
    ST_HALT = 4'h4,
    ST_RESET = 4'h8
  } brh_state_t;
endpackage
`default_nettype wire

// ===== testbench/brh_phase_model.sv
`default_nettype none
module brh_phase_model (
  input wire logic i_clk,
  input wire logic i_steal,
  output logic o_phi1,
  output logic o_phi2,
  output logic o_data_drive_strobe,
  output logic o_three_state_control
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic hold = 1'b0;
  // a steal only starts as phi1 rises, then freezes phi1 high, phi2 low
  wire logic next_hold = i_steal && (hold || cnt == 4'h0);
  always @(posedge i_clk) begin
    hold <= next_hold;
    if (!(next_hold && hold)) begin
      cnt <= cnt + 4'h1;
    end
  end
  assign o_three_state_control = hold;
  // idle slots 0, 7, 8 and 15 keep the two phases from overlapping
  assign o_phi1 = cnt >= 4'h1 && cnt <= 4'h6;
  assign o_phi2 = cnt >= 4'h9 && cnt <= 4'he;
  assign o_data_drive_strobe = o_phi2;
endmodule // brh_phase_model
`default_nettype wire

// ===== testbench/cpu_bus_release_halt_control_bench.sv
`default_nettype none
module cpu_bus_release_halt_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_n = 1'b0, steal = 1'b0;
  logic i_phi1, i_phi2, i_data_drive_strobe, i_three_state_control;
  logic i_halt_n = 1'b1, i_res_n = 1'b1, i_irq_n = 1'b1, i_nmi_n = 1'b1;
  logic [15:0] i_core_addr = 16'h1234;
  logic i_core_rw = 1'b1, i_core_valid_addr = 1'b1, i_core_last_cycle = 1'b1;
  logic [7:0] i_core_wdata = 8'ha5;
  logic i_core_irq_ack = 1'b0, i_core_nmi_ack = 1'b0, i_core_res_ack = 1'b0;
  logic [15:0] o_addr;
  logic [7:0] o_data;
  logic o_addr_oe_n, o_rw, o_rw_oe_n, o_data_oe_n, o_valid_memory_address;
  logic o_ba, o_core_run, o_core_irq_pend, o_core_nmi_pend, o_core_res_pend;
  int fail_count = 0, samples_checked = 0;

  brh_phase_model u_far (.i_clk, .i_steal(steal), .o_phi1(i_phi1),
    .o_phi2(i_phi2), .o_data_drive_strobe(i_data_drive_strobe),
    .o_three_state_control(i_three_state_control));
  brh_bus_release_ctrl dut (.i_clk, .i_rst_n, .i_phi1, .i_phi2,
    .i_data_drive_strobe, .i_three_state_control, .i_halt_n, .i_res_n,
    .i_irq_n, .i_nmi_n, .i_core_addr, .i_core_rw, .i_core_valid_addr,
    .i_core_wdata, .i_core_last_cycle, .i_core_irq_ack, .i_core_nmi_ack,
    .i_core_res_ack,
    .o_addr, .o_addr_oe_n, .o_rw, .o_rw_oe_n, .o_data, .o_data_oe_n,
    .o_valid_memory_address, .o_ba, .o_core_run, .o_core_irq_pend,
    .o_core_nmi_pend, .o_core_res_pend);

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // bounded so a stuck flag ends in a mismatch, not a hang
  task automatic wait_ba(input logic v);
    for (int i = 0; i < 200 && o_ba !== v; i++) tk(1);
  endtask

  // lands five clocks into a fresh strobe level, for a high level the last high slot of a strobe pulse, just past the sync latency
  task automatic strobe_edge(input logic lvl);
    while (i_data_drive_strobe === lvl) tk(1);
    while (i_data_drive_strobe !== lvl) tk(1);
    tk(4);
  endtask

  task automatic t_data();
    i_core_rw <= 1'b0;
    strobe_edge(1'b1);
    #1 chk({o_data_oe_n, o_valid_memory_address, o_data}, 10'h1a5);
    chk(o_addr, i_core_addr);
    strobe_edge(1'b0);
    #1 chk(o_data_oe_n, 1'b1);
    tk(1);
    i_core_rw <= 1'b1;
    strobe_edge(1'b1);
    #1 chk(o_data_oe_n, 1'b1);
  endtask

  task automatic t_steal();
    steal <= 1'b1;
    tk(40);
    #1 chk({o_addr_oe_n, o_rw_oe_n, o_valid_memory_address}, 3'b110);
    chk(o_ba, 1'b0);
    tk(1);
    steal <= 1'b0;
    tk(20);
  endtask

  task automatic t_halt();
    // no instruction ends here, so a low halt must not stop the core
    i_core_last_cycle <= 1'b0;
    i_halt_n <= 1'b0;
    tk(48);
    #1 chk({o_ba, o_core_run}, 2'b01);
    tk(1);
    i_core_last_cycle <= 1'b1;
    wait_ba(1'b1);
    #1 chk(o_ba, 1'b1);
    chk({o_addr_oe_n, o_rw_oe_n, o_data_oe_n}, 3'b111);
    chk({o_valid_memory_address, o_core_run}, 2'b00);
    tk(1);
    i_nmi_n <= 1'b0;
    i_irq_n <= 1'b0;
    tk(3);
    i_nmi_n <= 1'b1;
    tk(10);
    #1 chk({o_core_irq_pend, o_core_nmi_pend, o_core_run}, 3'b110);
    tk(1);
    t_steal();
    #1 chk(o_ba, 1'b1);
    while (!i_phi2) tk(1);
    while (i_phi2) tk(1);
    i_halt_n <= 1'b1;
    tk(16);
    i_halt_n <= 1'b0;
    wait_ba(1'b0);
    #1 chk(o_ba, 1'b0);
    wait_ba(1'b1);
    #1 chk(o_ba, 1'b1);
    tk(1);
    i_halt_n <= 1'b1;
    i_irq_n <= 1'b1;
    wait_ba(1'b0);
    tk(2);
    #1 chk({o_core_run, o_addr_oe_n, o_rw_oe_n}, 3'b100);
    tk(1);
    {i_core_irq_ack, i_core_nmi_ack} <= 2'b11;
    tk(1);
    {i_core_irq_ack, i_core_nmi_ack} <= 2'b00;
    tk(2);
    #1 chk({o_core_irq_pend, o_core_nmi_pend}, 2'b00);
  endtask

  task automatic t_reset(input logic halted);
    if (halted) begin
      i_halt_n <= 1'b0;
      wait_ba(1'b1);
    end
    i_res_n <= 1'b0;
    tk(8);
    #1 chk(o_addr, 16'hfffe);
    chk({o_addr_oe_n, o_rw, o_rw_oe_n, o_data_oe_n}, 4'h5);
    chk({o_valid_memory_address, o_ba, o_core_res_pend}, 3'b001);
    tk(52);
    i_res_n <= 1'b1;
    i_halt_n <= 1'b1;
    tk(10);
    i_core_res_ack <= 1'b1;
    tk(1);
    i_core_res_ack <= 1'b0;
    tk(2);
    #1 chk(o_core_res_pend, 1'b0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    tk(8);
    i_rst_n <= 1'b1;
    tk(20);
    t_data();
    tk(1);
    t_steal();
    t_halt();
    tk(1);
    t_reset(1'b0);
    tk(1);
    t_reset(1'b1);
    end_sim();
  end

  // the whole sequence needs well under a tenth of this span
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule // cpu_bus_release_halt_control_bench
`default_nettype wire
